// ===== hdl/bcc_pkg.sv
// Functional notes
// - Three modes only: charge, boost to the bus supply, high impedance.
// - High impedance turns boost and charger off and blocks current both ways.
// - Below the short-battery threshold pre-charge linearly, then start switched charging.
// - Switched charging runs at constant current with a slew-limited current reference.
// - Reaching the float voltage moves charging from current to voltage regulation.
// - With termination enabled, termination current ends the charge cycle.
// - Clearing the termination-enable bit disables current-based termination.
// - Float voltage is 3.50 V plus 20 mV per code, saturating at 4.44 V.
// - Charge current, input limit and termination codes sit in their register fields.
// - Float-voltage and weak-battery codes sit in host-writable register fields.
// - Battery falling below float minus recharge offset starts a new cycle.
// - Bus power-on reset clearing with a weak battery starts a new cycle.
// - Host clearing charger-disable or high-impedance request starts a new cycle.
// - On termination report ready for about 500 ms, then charge done if still connected.
// - Bus supply must stay valid for 30 ms before any charge start or restart.
package bcc_pkg;
   // Clock and timing.
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned VBUS_VALID_MS = 30;
   localparam int unsigned READY_HOLD_MS = 500;
   localparam int unsigned SLEW_STEP_US  = 1000;
   localparam int unsigned VBUS_VALID_CYC = VBUS_VALID_MS * (CLK_HZ / 1000);
   localparam int unsigned READY_HOLD_CYC = READY_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned SLEW_STEP_CYC  = SLEW_STEP_US * (CLK_HZ / 1_000_000);
   // Register indices; byte address is four times the index.
   localparam logic [2:0] IDX_STATUS = 3'h0;
   localparam logic [2:0] IDX_CTRL1  = 3'h1;
   localparam logic [2:0] IDX_FLOAT  = 3'h2;
   localparam logic [2:0] IDX_CURR   = 3'h4;
   // Control register one, float and current register fields.
   localparam int CTRL1_ILIM_LSB = 6;
   localparam int CTRL1_WEAK_LSB = 4;
   localparam int CTRL1_TE_BIT   = 3;
   localparam int CTRL1_CD_BIT   = 2;
   localparam int CTRL1_HZ_BIT   = 1;
   localparam int CTRL1_BST_BIT  = 0;
   localparam int FLOAT_LSB      = 2;
   localparam int CURR_CHG_LSB   = 4;
   localparam int CURR_TERM_LSB  = 0;
   // Reset values.
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [5:0] FLOAT_RST = 6'h02;
   localparam logic [2:0] CHG_RST   = 3'h0;
   localparam logic [2:0] TERM_RST  = 3'h0;
   // Float voltage decode in millivolts.
   localparam logic [12:0] FV_BASE_MV = 13'h0dac;
   localparam logic [12:0] FV_STEP_MV = 13'h0014;
   localparam logic [12:0] FV_MAX_MV  = 13'h1158;
   localparam logic [5:0]  FV_SAT_CODE = 6'h2f;
   // Status field and host-visible phase codes.
   localparam logic [1:0] STAT_READY = 2'h0;
   localparam logic [1:0] STAT_CHG   = 2'h1;
   localparam logic [1:0] STAT_DONE  = 2'h2;
   localparam logic [2:0] PH_IDLE = 3'h0;
   localparam logic [2:0] PH_QUAL = 3'h1;
   localparam logic [2:0] PH_PRE  = 3'h2;
   localparam logic [2:0] PH_CC   = 3'h3;
   localparam logic [2:0] PH_CV   = 3'h4;
   localparam logic [2:0] PH_TERM = 3'h5;
   localparam logic [2:0] PH_DONE = 3'h6;
   // Comparator inputs as one bundle.
   typedef struct packed {
      logic vbus_valid;
      logic bat_below_short;
      logic bat_at_float;
      logic bat_below_recharge;
      logic bat_below_weak;
      logic at_term_current;
      logic bat_present;
   } bcc_cmp_s;
   // Power stage drive bundle.
   typedef struct packed {
      logic precharge_en;
      logic pwm_en;
      logic cv_phase;
      logic boost_en;
      logic path_block;
   } bcc_drive_s;
   // Settings handed to the analog loops.
   typedef struct packed {
      logic [12:0] float_voltage_level;
      logic [2:0]  current_ref;
      logic [1:0]  input_current_limit_code;
      logic [2:0]  termination_current_code;
      logic [1:0]  weak_battery_threshold;
   } bcc_set_s;
endpackage : bcc_pkg

// ===== hdl/bcc_top.sv
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module bcc_top #(
   parameter int unsigned VBUS_VALID_CYC = bcc_pkg::VBUS_VALID_CYC,
   parameter int unsigned READY_HOLD_CYC = bcc_pkg::READY_HOLD_CYC,
   parameter int unsigned SLEW_STEP_CYC  = bcc_pkg::SLEW_STEP_CYC
) (
   // Clock and reset.
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave.
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [4:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic      [31:0]        dat_o,
   output logic                    ack_o,
   // Analog comparators.
   input  wire bcc_pkg::bcc_cmp_s  cmp_i,
   // Power stage.
   output bcc_pkg::bcc_drive_s     drive_o,
   output bcc_pkg::bcc_set_s       set_o
);
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_QUAL  = 9'h002,
      ST_PRE   = 9'h004,
      ST_CC    = 9'h008,
      ST_CV    = 9'h010,
      ST_TERM  = 9'h020,
      ST_DONE  = 9'h040,
      ST_HIZ   = 9'h080,
      ST_BOOST = 9'h100
   } bcc_state_e;

   bcc_state_e        state_ff, nxt_state;
   bcc_pkg::bcc_cmp_s meta_ff, cmp_ff;
   logic [7:0]        ctrl1_ff;
   logic [5:0]        float_ff;
   logic [2:0]        chg_ff, term_ff;
   logic              ack_ff;
   logic [31:0]       rdat_ff;
   logic [31:0]       vcnt_ff;
   logic              vok_ff;
   logic [31:0]       hcnt_ff;
   logic [31:0]       scnt_ff;
   logic [2:0]        iref_ff;
   logic              restart_ff;
   bcc_pkg::bcc_drive_s drive_ff;

   // Comparators pass two flops before anything looks at them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         cmp_ff  <= '0;
      end else begin
         meta_ff <= cmp_i;
         cmp_ff  <= meta_ff;
      end
   end

   // Bus decode.
   // Only the low byte lane holds a register, so sel_i[0] alone gates writes.
   wire       req      = cyc_i & stb_i & ~ack_ff;
   wire [2:0] idx      = adr_i[4:2];
   wire       wr_lane  = req & we_i & sel_i[0];
   wire       wr_ctrl1 = wr_lane & (idx == bcc_pkg::IDX_CTRL1);
   wire       wr_float = wr_lane & (idx == bcc_pkg::IDX_FLOAT);
   wire       wr_curr  = wr_lane & (idx == bcc_pkg::IDX_CURR);
   wire [7:0] wbyte    = dat_i[7:0];

   // Control fields.
   wire te      = ctrl1_ff[bcc_pkg::CTRL1_TE_BIT];
   wire chg_dis = ctrl1_ff[bcc_pkg::CTRL1_CD_BIT];
   wire hz_req  = ctrl1_ff[bcc_pkg::CTRL1_HZ_BIT];
   wire bst_req = ctrl1_ff[bcc_pkg::CTRL1_BST_BIT];

   // A restart only on a one-to-zero change by the host.
   wire cd_clear = wr_ctrl1 & chg_dis & ~wbyte[bcc_pkg::CTRL1_CD_BIT];
   wire hz_clear = wr_ctrl1 & hz_req & ~wbyte[bcc_pkg::CTRL1_HZ_BIT];

   // Bus validation window and power-on-reset release.
   wire vbus_ok_now = vcnt_ff >= VBUS_VALID_CYC;
   wire por_clear   = vbus_ok_now & ~vok_ff;
   wire qual_entry  = (nxt_state == ST_QUAL) & (state_ff != ST_QUAL);

   // A clearing write is held over one cycle, so that the start is judged
   // against the control value that the same write stored; judged on the old
   // value, the very bit being cleared would still veto the start.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         restart_ff <= 1'b0;
      end else begin
         restart_ff <= cd_clear | hz_clear;
      end
   end

   // Start conditions for a fresh cycle.
   wire rch_start = (state_ff == ST_DONE) & cmp_ff.bat_below_recharge;
   wire por_start = por_clear & cmp_ff.bat_below_weak;
   wire reg_start = restart_ff;
   wire start_req = rch_start | por_start | reg_start;
   wire chg_allow = ~hz_req & ~chg_dis & ~bst_req;

   // Float voltage decode with saturation.
   wire [12:0] fv_lin = 13'(bcc_pkg::FV_BASE_MV + bcc_pkg::FV_STEP_MV * 13'(float_ff));
   wire [12:0] fv_mv  = (float_ff >= bcc_pkg::FV_SAT_CODE) ? bcc_pkg::FV_MAX_MV : fv_lin;

   // Host-visible phase code.
   wire [2:0] phase =
      (state_ff == ST_QUAL) ? bcc_pkg::PH_QUAL :
      (state_ff == ST_PRE)  ? bcc_pkg::PH_PRE  :
      (state_ff == ST_CC)   ? bcc_pkg::PH_CC   :
      (state_ff == ST_CV)   ? bcc_pkg::PH_CV   :
      (state_ff == ST_TERM) ? bcc_pkg::PH_TERM :
      (state_ff == ST_DONE) ? bcc_pkg::PH_DONE : bcc_pkg::PH_IDLE;

   // Ready while terminating, done after the hold, charging in active phases.
   wire [1:0] stat =
      (state_ff == ST_DONE) ? bcc_pkg::STAT_DONE :
      (state_ff == ST_PRE || state_ff == ST_CC || state_ff == ST_CV) ?
         bcc_pkg::STAT_CHG : bcc_pkg::STAT_READY;

   wire [7:0] status_byte = {1'b0, state_ff == ST_HIZ, state_ff == ST_BOOST, phase, stat};

   wire [31:0] rd_mux =
      (idx == bcc_pkg::IDX_STATUS) ? {24'h000000, status_byte} :
      (idx == bcc_pkg::IDX_CTRL1)  ? {24'h000000, ctrl1_ff} :
      (idx == bcc_pkg::IDX_FLOAT)  ? {24'h000000, float_ff, 2'h0} :
      (idx == bcc_pkg::IDX_CURR)   ? {24'h000000, 1'b0, chg_ff, 1'b0, term_ff} :
      32'h00000000;

   // Slave answers one cycle after the request; unmapped reads return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff  <= req;
         rdat_ff <= req ? rd_mux : rdat_ff;
      end
   end

   // Host registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl1_ff <= bcc_pkg::CTRL1_RST;
         float_ff <= bcc_pkg::FLOAT_RST;
         chg_ff   <= bcc_pkg::CHG_RST;
         term_ff  <= bcc_pkg::TERM_RST;
      end else begin
         if (wr_ctrl1) begin
            ctrl1_ff <= wbyte;
         end
         if (wr_float) begin
            float_ff <= wbyte[7:bcc_pkg::FLOAT_LSB];
         end
         if (wr_curr) begin
            chg_ff  <= wbyte[bcc_pkg::CURR_CHG_LSB +: 3];
            term_ff <= wbyte[bcc_pkg::CURR_TERM_LSB +: 3];
         end
      end
   end

   // Bus-valid counter restarts on any drop and at each qualification entry.
   // Saturating at the window keeps the count from wrapping during long charges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vcnt_ff <= 32'h00000000;
         vok_ff  <= 1'b0;
      end else begin
         vok_ff <= vbus_ok_now;
         if (!cmp_ff.vbus_valid || qual_entry) begin
            vcnt_ff <= 32'h00000000;
         end else if (!vbus_ok_now) begin
            vcnt_ff <= vcnt_ff + 32'h00000001;
         end
      end
   end

   // Ready-hold timer runs only in the termination state.
   // Clearing it outside that state gives every termination a full hold.
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != ST_TERM) begin
         hcnt_ff <= 32'h00000000;
      end else begin
         hcnt_ff <= hcnt_ff + 32'h00000001;
      end
   end
   wire hold_done = hcnt_ff >= READY_HOLD_CYC - 1;

   // Slew divider gives one step enable per period.
   // The divider runs free, so the first step after entry may come early.
   wire slew_en = scnt_ff >= SLEW_STEP_CYC - 1;
   always_ff @(posedge clk_i) begin
      if (rst_i || slew_en) begin
         scnt_ff <= 32'h00000000;
      end else begin
         scnt_ff <= scnt_ff + 32'h00000001;
      end
   end

   // Current reference ramps up one code per step to avoid overshoot;
   // a lowered setting takes effect at once since that is always safe.
   wire pwm_phase = (state_ff == ST_CC) | (state_ff == ST_CV);
   always_ff @(posedge clk_i) begin
      if (rst_i || !pwm_phase) begin
         iref_ff <= 3'h0;
      end else if (iref_ff > chg_ff) begin
         iref_ff <= chg_ff;
      end else if (slew_en && iref_ff < chg_ff) begin
         iref_ff <= iref_ff + 3'h1;
      end
   end

   // Phase sequencing; high impedance wins over boost, boost over charge.
   always_comb begin
      nxt_state = state_ff;
      if (hz_req) begin
         nxt_state = ST_HIZ;
      end else if (bst_req) begin
         nxt_state = ST_BOOST;
      end else begin
         unique case (state_ff)
            ST_IDLE, ST_HIZ, ST_BOOST: begin
               if (start_req && chg_allow) begin
                  nxt_state = ST_QUAL;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
            ST_QUAL: begin
               // The window count was cleared on entry, so a full window is waited.
               if (chg_dis) begin
                  nxt_state = ST_IDLE;
               end else if (vbus_ok_now) begin
                  nxt_state = cmp_ff.bat_below_short ? ST_PRE : ST_CC;
               end
            end
            ST_PRE: begin
               if (!cmp_ff.bat_below_short) begin
                  nxt_state = ST_CC;
               end
            end
            ST_CC: begin
               if (cmp_ff.bat_at_float) begin
                  nxt_state = ST_CV;
               end
            end
            ST_CV: begin
               if (te && cmp_ff.at_term_current) begin
                  nxt_state = ST_TERM;
               end
            end
            ST_TERM: begin
               if (hold_done) begin
                  nxt_state = (cmp_ff.bat_present && cmp_ff.vbus_valid) ? ST_DONE : ST_IDLE;
               end
            end
            ST_DONE: begin
               // Any start condition restarts, a weak cell at bus return included.
               if (start_req) begin
                  nxt_state = ST_QUAL;
               end
            end
            default: nxt_state = ST_IDLE;
         endcase
         // Charging phases stop when the bus is lost or the host disables.
         if ((state_ff == ST_PRE || pwm_phase) && (!cmp_ff.vbus_valid || chg_dis)) begin
            nxt_state = ST_IDLE;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Power stage drive, registered so the pins never glitch.
   // The path stays blocked while idle so that a dead input cannot drain the cell.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_ff <= '{precharge_en: 1'b0, pwm_en: 1'b0, cv_phase: 1'b0,
                       boost_en: 1'b0, path_block: 1'b1};
      end else begin
         drive_ff.precharge_en <= nxt_state == ST_PRE;
         drive_ff.pwm_en       <= nxt_state == ST_CC || nxt_state == ST_CV;
         drive_ff.cv_phase     <= nxt_state == ST_CV;
         drive_ff.boost_en     <= nxt_state == ST_BOOST;
         drive_ff.path_block   <= nxt_state == ST_HIZ || nxt_state == ST_IDLE;
      end
   end

   assign dat_o   = rdat_ff;
   assign ack_o   = ack_ff;
   assign drive_o = drive_ff;
   assign set_o   = '{float_voltage_level: fv_mv, current_ref: iref_ff,
                      input_current_limit_code: ctrl1_ff[bcc_pkg::CTRL1_ILIM_LSB +: 2],
                      termination_current_code: term_ff,
                      weak_battery_threshold: ctrl1_ff[bcc_pkg::CTRL1_WEAK_LSB +: 2]};
endmodule : bcc_top
`default_nettype wire

// ===== tb/bcc_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_sva #(
   parameter int unsigned VBUS_VALID_CYC = 20
) (
   // Clock, reset and bus handshake.
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic                ack_o,
   // Comparators and power stage.
   input wire bcc_pkg::bcc_cmp_s   cmp_i,
   input wire bcc_pkg::bcc_drive_s drive_o,
   input wire bcc_pkg::bcc_set_s   set_o
);
   logic [31:0] vcnt_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Counts how long the bus supply has been valid without a break.
   always_ff @(posedge clk_i) begin
      vcnt_ff <= (rst_i || !cmp_i.vbus_valid) ? 32'h0 : vcnt_ff + 32'h1;
   end
   property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_one_mode; !(drive_o.boost_en && (drive_o.pwm_en || drive_o.precharge_en));
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("boost and charge together");
   property p_hz; drive_o.path_block |-> drive_o[4:1] == 4'h0; endproperty
   a_hz: assert property (p_hz) else $error("blocked path with stage running");
   property p_pre; !(drive_o.precharge_en && drive_o.pwm_en); endproperty
   a_pre: assert property (p_pre) else $error("linear and switched charge together");
   property p_slew;
      set_o.current_ref > $past(set_o.current_ref) |->
         set_o.current_ref == $past(set_o.current_ref) + 3'h1;
   endproperty
   a_slew: assert property (p_slew) else $error("current reference jumped up");
   property p_cv; drive_o.cv_phase |-> drive_o.pwm_en; endproperty
   a_cv: assert property (p_cv) else $error("voltage phase without switching");
   property p_fv;
      set_o.float_voltage_level <= 13'h1158 && set_o.float_voltage_level >= 13'h0dac;
   endproperty
   a_fv: assert property (p_fv) else $error("float level out of range");
   property p_vbus;
      $rose(drive_o.pwm_en) || $rose(drive_o.precharge_en) |-> vcnt_ff >= VBUS_VALID_CYC;
   endproperty
   a_vbus: assert property (p_vbus) else $error("charge began before supply settled");
   property p_rst; $fell(rst_i) |-> drive_o == 5'h01; endproperty
   a_rst: assert property (p_rst) else $error("not idle after reset");
   c_pre: cover property ($rose(drive_o.precharge_en));
   c_cv: cover property ($rose(drive_o.cv_phase));
   c_boost: cover property ($rose(drive_o.boost_en));
endmodule : bcc_sva
bind bcc_top bcc_sva #(.VBUS_VALID_CYC(VBUS_VALID_CYC)) bcc_sva_i (.clk_i, .rst_i, .cyc_i,
   .stb_i, .ack_o, .cmp_i, .drive_o, .set_o);
`default_nettype wire

// ===== tb/bcc_batt.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_batt (
   // Clock and power stage drive.
   input wire logic                clk_i,
   input wire bcc_pkg::bcc_drive_s drive_i,
   input wire bcc_pkg::bcc_set_s   set_i,
   // Bench controls of supply and cell.
   input wire logic                vbus_i,
   input wire logic                present_i,
   input wire logic                load_i,
   input wire logic [12:0]         load_mv_i,
   // Comparator outputs.
   output bcc_pkg::bcc_cmp_s       cmp_o
);
   logic [12:0] vbat_ff;
   logic [3:0]  cvt_ff;
   // Cell voltage climbs while charged; current tapers only after some time in CV.
   always_ff @(posedge clk_i) begin
      if (load_i) vbat_ff <= load_mv_i;
      else if (drive_i.precharge_en) vbat_ff <= vbat_ff + 13'h1;
      else if (drive_i.pwm_en && vbat_ff < set_i.float_voltage_level) vbat_ff <= vbat_ff + 13'h2;
      cvt_ff <= drive_i.cv_phase ? cvt_ff + {3'h0, cvt_ff != 4'hf} : 4'h0;
   end
   // Thresholds: short 3.0 V, weak 3.4 V, recharge offset 100 mV.
   assign cmp_o = {vbus_i, vbat_ff < 13'hbb8, vbat_ff >= set_i.float_voltage_level,
                   vbat_ff < set_i.float_voltage_level - 13'h64, vbat_ff < 13'hd48,
                   cvt_ff == 4'hf, present_i};
endmodule : bcc_batt
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                clk_i   = 1'b0;
   logic                rst_i   = 1'b1;
   logic                cyc_i   = 1'b0;
   logic                stb_i   = 1'b0;
   logic                we_i    = 1'b0;
   logic [4:0]          adr_i   = 5'h00;
   logic [31:0]         dat_i   = 32'h0;
   logic [31:0]         dat_o;
   logic                ack_o;
   logic                vbus    = 1'b1;
   logic                present = 1'b1;
   logic                load    = 1'b1;
   logic [12:0]         load_mv = 13'haf0;
   logic [31:0]         st;
   int                  fail_count = 0;
   int                  checks = 0;
   bcc_pkg::bcc_cmp_s   cmp;
   bcc_pkg::bcc_drive_s drv;
   bcc_pkg::bcc_set_s   set;
   logic [4:0]          ra [5] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h0c};
   logic [31:0]         re [5] = '{32'h0, 32'h0, 32'h8, 32'h0, 32'h0};
   logic [5:0]          fc [5] = '{6'h00, 6'h01, 6'h2e, 6'h2f, 6'h3f};
   logic [12:0]         fe [5] = '{13'h0dac, 13'h0dc0, 13'h1144, 13'h1158, 13'h1158};
   // Half period of 25 ns gives the 20 MHz clock.
   always #25 clk_i = ~clk_i;
   // Long counts are shortened so the whole run stays brief.
   bcc_top #(.VBUS_VALID_CYC(20), .READY_HOLD_CYC(30), .SLEW_STEP_CYC(4)) bcc_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .cmp_i(cmp), .drive_o(drv), .set_o(set));
   bcc_batt bcc_batt_i (.clk_i(clk_i), .drive_i(drv), .set_i(set), .vbus_i(vbus),
      .present_i(present), .load_i(load), .load_mv_i(load_mv), .cmp_o(cmp));
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      st = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Polls the phase field; bounded so a stuck machine cannot hang the run.
   task automatic wait_ph(input logic [2:0] ph);
      int n;
      n = 0;
      wb(1'b0, 5'h00, 8'h00);
      while (st[4:2] !== ph && n < 500) begin
         wb(1'b0, 5'h00, 8'h00);
         n++;
      end
      chk(32'(st[4:2]), 32'(ph));
   endtask : wait_ph
   task automatic set_bat(input logic [12:0] mv);
      @(posedge clk_i);
      load_mv <= mv;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
   endtask : set_bat
   task automatic conclude;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // Main sequence: registers first, then a full charge cycle and its restarts.
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      load <= 1'b0;
      wb(1'b1, 5'h0c, 8'hff);
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, ra[i], 8'h00);
         chk(st, re[i]);
      end
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, 5'h08, {fc[i], 2'b00});
         wb(1'b0, 5'h08, 8'h00);
         chk(st, {24'h0, fc[i], 2'b00});
         chk(32'(set.float_voltage_level), 32'(fe[i]));
      end
      wb(1'b1, 5'h08, 8'h14);
      wb(1'b1, 5'h10, 8'h75);
      wb(1'b0, 5'h10, 8'h00);
      chk(st, 32'h75);
      wb(1'b1, 5'h04, 8'hcc);
      chk(32'({set.input_current_limit_code, set.termination_current_code,
               set.weak_battery_threshold}), 32'h74);
      wb(1'b1, 5'h04, 8'hc8);
      wait_ph(3'h2);
      wait_ph(3'h3);
      wait_ph(3'h4);
      wait_ph(3'h5);
      chk(32'(st[1:0]), 32'h0);
      wait_ph(3'h6);
      chk(32'(st[1:0]), 32'h2);
      set_bat(13'hd7a);
      wait_ph(3'h3);
      wait_ph(3'h6);
      wb(1'b1, 5'h04, 8'hc0);
      set_bat(13'hd7a);
      wait_ph(3'h4);
      repeat (60) @(posedge clk_i);
      wait_ph(3'h4);
      chk(32'(set.current_ref), 32'h7);
      wb(1'b1, 5'h04, 8'hc2);
      repeat (4) @(posedge clk_i);
      chk(32'(drv), 32'h01);
      wb(1'b0, 5'h00, 8'h00);
      chk(32'(st[6]), 32'h1);
      wb(1'b1, 5'h04, 8'hc0);
      wait_ph(3'h4);
      wb(1'b1, 5'h04, 8'hc1);
      repeat (4) @(posedge clk_i);
      chk(32'(drv), 32'h02);
      wb(1'b1, 5'h04, 8'hc0);
      vbus <= 1'b0;
      repeat (6) @(posedge clk_i);
      wait_ph(3'h0);
      set_bat(13'hce4);
      vbus <= 1'b1;
      wait_ph(3'h3);
      wb(1'b0, 5'h04, 8'h00);
      chk(st, 32'hc0);
      wb(1'b1, 5'h04, 8'hc8);
      wait_ph(3'h5);
      present <= 1'b0;
      wait_ph(3'h0);
      chk(32'(drv), 32'h01);
      conclude();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #2_000_000;
      fail_count++;
      conclude();
   end
endmodule : tb
`default_nettype wire
